// File: verilog/cccr_pkg.sv
// shared constants and carrier types for the can control and command registers
package cccr_pkg;
    // register addresses on the 8-bit host port
    localparam logic [7:0] CCCR_ADDR_CONTROL = 8'h20;
    localparam logic [7:0] CCCR_ADDR_COMMAND = 8'h21;
    localparam logic [7:0] CCCR_ADDR_ACC_CODE = 8'h24;
    localparam logic [7:0] CCCR_ADDR_OUT_CTRL = 8'h28;
    // control register field positions
    localparam int CTL_MODE = 7;
    localparam int CTL_SPD = 6;
    localparam int CTL_OIE = 4;
    localparam int CTL_EIE = 3;
    localparam int CTL_TIE = 2;
    localparam int CTL_RIE = 1;
    localparam int CTL_RR = 0;
    // command register field positions
    localparam int CMD_RXA = 7;
    localparam int CMD_RXB = 6;
    localparam int CMD_CSEL = 5;
    localparam int CMD_SLEEP = 4;
    localparam int CMD_COS = 3;
    localparam int CMD_RRB = 2;
    localparam int CMD_AT = 1;
    localparam int CMD_TR = 0;
    // values after reset, and the value a command read returns
    localparam logic [7:0] CTL_RESET_VALUE = 8'h01;
    localparam logic [7:0] CMD_RESET_VALUE = 8'h00;
    localparam logic [7:0] CMD_READ_VALUE = 8'hFF;
    // recovery counts
    localparam int RECESSIVE_RUN_BITS = 11;
    localparam logic [3:0] RUN_LAST = 4'(RECESSIVE_RUN_BITS - 1);
    localparam int BUS_OFF_RUNS = 128;
    localparam logic [7:0] RUNS_LAST = 8'(BUS_OFF_RUNS - 1);

    // reset state machine
    typedef enum logic [3:0] {
        CCCR_RUN = 4'b0001,
        CCCR_HELD = 4'b0010,
        CCCR_WAIT_ONE = 4'b0100,
        CCCR_WAIT_MANY = 4'b1000
    } cccr_state_e;

    // one-shot command pulses toward the core
    typedef struct packed {
        logic clear_overrun;
        logic release_rx_buffer;
        logic abort_tx;
        logic tx_request;
    } cccr_cmd_s;

    // status events from the core
    typedef struct packed {
        logic overrun_set;
        logic error_change;
        logic tx_done;
        logic abort_released;
        logic rx_done;
        logic bus_off;
        logic receiving;
        logic transmitting;
        logic bit_tick;
        logic bus_level;
    } cccr_core_s;
endpackage

// File: verilog/cccr_run_counter.sv
// counts runs of recessive bits for the return to normal operation
`timescale 1ns/1ps
module cccr_run_counter (
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    input wire logic many,
    input wire logic bit_tick,
    input wire logic bus_level,
    output logic done
);
    import cccr_pkg::*;

    logic [3:0] bits_reg; // recessive bits seen in the current run
    logic [7:0] runs_reg; // completed runs of eleven
    logic run_end; // the eleventh recessive bit arrives now

    assign run_end = enable && bit_tick && bus_level && (bits_reg == RUN_LAST);

    // bit counter, restarted by any dominant bit
    always_ff @(posedge clock) begin
        if (reset || !enable) begin
            bits_reg <= 4'h0;
        end else if (bit_tick) begin
            if (!bus_level || run_end) begin
                bits_reg <= 4'h0;
            end else begin
                bits_reg <= bits_reg + 4'h1;
            end
        end
    end

    // run counter; one run suffices unless coming back from bus off
    always_ff @(posedge clock) begin
        if (reset || !enable) begin
            runs_reg <= 8'h00;
        end else if (run_end) begin
            runs_reg <= runs_reg + 8'h01;
        end
    end

    // done is a one-cycle pulse at the final run
    assign done = run_end && (!many || runs_reg == RUNS_LAST);
endmodule

// File: verilog/cccr_regs.sv
// control and command register logic of the can controller
`timescale 1ns/1ps
module cccr_regs (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic host_write,
    input wire logic host_read,
    output logic [7:0] host_rdata,
    input wire cccr_pkg::cccr_core_s core_in,
    input wire logic irq_pending,
    input wire logic bus_idle,
    output cccr_pkg::cccr_cmd_s cmd_pulse,
    output logic [7:0] control_out,
    output logic core_in_reset,
    output logic counters_clear,
    output logic filter_access,
    output logic resync_both_edges,
    output logic rx_pin_a_bias,
    output logic rx_pin_b_bias,
    output logic sleep_comparator_select,
    output logic sleeping,
    output logic wake_irq,
    output logic overrun_irq,
    output logic error_irq,
    output logic tx_irq,
    output logic rx_irq,
    output logic rx_enable,
    output logic tx_complete_flag,
    output logic overrun_flag
);
    import cccr_pkg::*;

    logic [7:0] can_control_reg; // host control register
    logic [7:0] can_command_reg; // level bits of the command register
    logic [7:0] host_rdata_reg; // registered read data
    cccr_cmd_s cmd_reg; // one-cycle command pulses
    cccr_state_e state_reg; // reset state machine
    logic from_bus_off_reg; // reset request raised by bus off
    logic rx_pending_reg; // release waiting for reception start
    logic sleeping_reg; // sleep mode entered
    logic wait_eof_reg; // woken by bus, waiting for end of frame
    logic wake_irq_reg;
    logic overrun_irq_reg;
    logic error_irq_reg;
    logic tx_irq_reg;
    logic rx_irq_reg;
    logic tx_complete_reg;
    logic overrun_reg;
    logic rx_enable_reg;
    logic counters_clear_reg;
    logic ctl_write; // host write to control
    logic cmd_write; // host write to command, taken only outside reset
    logic recover_done; // recessive run count finished
    logic eof_done; // end of frame seen after wake
    logic sleep_set; // host asks for sleep now

    assign ctl_write = host_write && host_addr == CCCR_ADDR_CONTROL;
    // command writes honoured only outside reset
    assign cmd_write = host_write && host_addr == CCCR_ADDR_COMMAND
        && !can_control_reg[CTL_RR];
    // key on the sleep state: a refused attempt leaves the level bit set
    assign sleep_set = cmd_write && host_wdata[CMD_SLEEP] && !sleeping_reg;

    // shared counter serves both bus recovery and wake end of frame
    cccr_run_counter u_run (
        .clock(clock),
        .reset(reset),
        .enable((state_reg == CCCR_WAIT_ONE) || (state_reg == CCCR_WAIT_MANY) || wait_eof_reg),
        .many(state_reg == CCCR_WAIT_MANY),
        .bit_tick(core_in.bit_tick),
        .bus_level(core_in.bus_level),
        .done(recover_done)
    );
    assign eof_done = recover_done && wait_eof_reg;

    // control register; all bits host written, core touches only reset_request
    always_ff @(posedge clock) begin
        if (reset) begin
            can_control_reg <= CTL_RESET_VALUE;
        end else begin
            if (ctl_write) begin
                can_control_reg <= host_wdata;
            end
            if (core_in.bus_off && state_reg == CCCR_RUN) begin
                can_control_reg[CTL_RR] <= 1'b1;
            end
        end
    end

    // reset state machine, exits after recessive runs
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= CCCR_HELD;
            from_bus_off_reg <= 1'b0;
        end else begin
            case (state_reg)
                CCCR_RUN: begin
                    if (can_control_reg[CTL_RR] || core_in.bus_off) begin
                        state_reg <= CCCR_HELD;
                        from_bus_off_reg <= core_in.bus_off;
                    end
                end
                CCCR_HELD: begin
                    // only a host clear leaves reset
                    if (!can_control_reg[CTL_RR]) begin
                        state_reg <= from_bus_off_reg ? CCCR_WAIT_MANY : CCCR_WAIT_ONE;
                    end
                end
                CCCR_WAIT_ONE, CCCR_WAIT_MANY: begin
                    if (can_control_reg[CTL_RR]) begin
                        state_reg <= CCCR_HELD;
                    end else if (recover_done) begin
                        state_reg <= CCCR_RUN;
                        from_bus_off_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= CCCR_HELD;
                end
            endcase
        end
    end

    // error counters cleared only after bus off recovery
    always_ff @(posedge clock) begin
        if (reset) begin
            counters_clear_reg <= 1'b0;
        end else begin
            counters_clear_reg <= recover_done && state_reg == CCCR_WAIT_MANY;
        end
    end

    // command level bits, cleared while reset_request is present
    always_ff @(posedge clock) begin
        if (reset || can_control_reg[CTL_RR]) begin
            can_command_reg <= CMD_RESET_VALUE;
        end else if (cmd_write) begin
            can_command_reg <= host_wdata;
        end else if (sleeping_reg && core_in.bus_level == 1'b0) begin
            // bus activity clears sleep
            can_command_reg[CMD_SLEEP] <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_reg <= '0;
        end else begin
            cmd_reg.clear_overrun <= cmd_write && host_wdata[CMD_COS];
            cmd_reg.abort_tx <= cmd_write && host_wdata[CMD_AT];
            // a zero writes no pulse, earlier request stays
            cmd_reg.tx_request <= cmd_write && host_wdata[CMD_TR];
            cmd_reg.release_rx_buffer <= cmd_write && host_wdata[CMD_RRB];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_pending_reg <= 1'b0;
        end else if (cmd_write && host_wdata[CMD_RRB]) begin
            rx_pending_reg <= 1'b1;
        end else if (core_in.receiving) begin
            rx_pending_reg <= 1'b0;
        end
    end

    // tx_complete cleared by new request, set on success
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_complete_reg <= 1'b0;
        end else if (core_in.tx_done) begin
            tx_complete_reg <= 1'b1;
        end else if (cmd_write && host_wdata[CMD_TR]) begin
            tx_complete_reg <= 1'b0;
        end
    end

    // overrun status; a new overrun wins over a clear
    always_ff @(posedge clock) begin
        if (reset) begin
            overrun_reg <= 1'b0;
        end else if (core_in.overrun_set) begin
            overrun_reg <= 1'b1;
        end else if (cmd_write && host_wdata[CMD_COS]) begin
            overrun_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || can_control_reg[CTL_RR]) begin
            sleeping_reg <= 1'b0;
        end else if (sleep_set && !irq_pending && bus_idle
            && !core_in.receiving && !core_in.transmitting) begin
            sleeping_reg <= 1'b1;
        end else if (!can_command_reg[CMD_SLEEP] || (cmd_write && !host_wdata[CMD_SLEEP])) begin
            sleeping_reg <= 1'b0;
        end else if (sleeping_reg && !core_in.bus_level) begin
            sleeping_reg <= 1'b0;
        end
    end

    // after a bus wake, hold reception until end of frame
    always_ff @(posedge clock) begin
        if (reset) begin
            wait_eof_reg <= 1'b0;
            rx_enable_reg <= 1'b0;
        end else begin
            if (sleeping_reg && !core_in.bus_level) begin
                wait_eof_reg <= 1'b1;
            end else if (eof_done) begin
                wait_eof_reg <= 1'b0;
            end
            rx_enable_reg <= state_reg == CCCR_RUN && !sleeping_reg && !wait_eof_reg;
        end
    end

    // interrupt requests; one-cycle pulses that drop the next cycle with no read needed
    always_ff @(posedge clock) begin
        if (reset) begin
            wake_irq_reg <= 1'b0;
        end else if (sleeping_reg && !core_in.bus_level) begin
            wake_irq_reg <= 1'b1;
        end else if (sleep_set && (irq_pending || !bus_idle
            || core_in.receiving || core_in.transmitting)) begin
            // sleep refused during traffic or with an interrupt pending, wake at once
            wake_irq_reg <= 1'b1;
        end else begin
            wake_irq_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            overrun_irq_reg <= 1'b0;
            error_irq_reg <= 1'b0;
        end else begin
            overrun_irq_reg <= core_in.overrun_set && can_control_reg[CTL_OIE];
            error_irq_reg <= core_in.error_change && can_control_reg[CTL_EIE];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_irq_reg <= 1'b0;
            rx_irq_reg <= 1'b0;
        end else begin
            tx_irq_reg <= (core_in.tx_done || core_in.abort_released)
                && can_control_reg[CTL_TIE];
            rx_irq_reg <= core_in.rx_done && can_control_reg[CTL_RIE];
        end
    end

    // read path; command reads as all ones
    always_ff @(posedge clock) begin
        if (reset) begin
            host_rdata_reg <= 8'h00;
        end else if (host_read) begin
            if (host_addr == CCCR_ADDR_CONTROL) begin
                host_rdata_reg <= can_control_reg;
            end else if (host_addr == CCCR_ADDR_COMMAND) begin
                host_rdata_reg <= CMD_READ_VALUE;
            end else begin
                host_rdata_reg <= 8'h00;
            end
        end
    end

    assign host_rdata = host_rdata_reg;
    assign cmd_pulse = cmd_reg;
    assign control_out = can_control_reg;
    assign core_in_reset = state_reg != CCCR_RUN;
    assign counters_clear = counters_clear_reg;
    // filter and timing access only in reset request
    assign filter_access = can_control_reg[CTL_RR];
    assign resync_both_edges = can_control_reg[CTL_SPD];
    // bias bits; equal bits bias neither pin
    assign rx_pin_a_bias = can_command_reg[CMD_RXA] && !can_command_reg[CMD_RXB];
    assign rx_pin_b_bias = can_command_reg[CMD_RXB] && !can_command_reg[CMD_RXA];
    assign sleep_comparator_select = can_command_reg[CMD_CSEL];
    assign sleeping = sleeping_reg;
    assign wake_irq = wake_irq_reg;
    assign overrun_irq = overrun_irq_reg;
    assign error_irq = error_irq_reg;
    assign tx_irq = tx_irq_reg;
    assign rx_irq = rx_irq_reg;
    assign rx_enable = rx_enable_reg;
    assign tx_complete_flag = tx_complete_reg;
    assign overrun_flag = overrun_reg;

    // bus off in the run state reaches reset_request next cycle
    a_bus_off_rr: assert property (@(posedge clock) disable iff (reset)
        core_in.bus_off |=> can_control_reg[CTL_RR]) else $error("bus off did not set request");
    a_cmd_read_ones: assert property (@(posedge clock) disable iff (reset)
        host_read && host_addr == CCCR_ADDR_COMMAND |=> host_rdata == 8'hFF)
        else $error("command read not all ones");
    a_tr_pulse: assert property (@(posedge clock) disable iff (reset)
        cmd_pulse.tx_request |=> !cmd_pulse.tx_request || $past(cmd_write))
        else $error("tx request pulse too long");
    a_no_cmd_rr: assert property (@(posedge clock) disable iff (reset)
        $past(can_control_reg[CTL_RR]) && $past(host_write) |-> cmd_pulse == '0)
        else $error("command taken in reset");
    // request held leaves the core in reset
    a_rr_holds: assert property (@(posedge clock) disable iff (reset)
        can_control_reg[CTL_RR] |=> core_in_reset) else $error("reset state not entered");
    a_tcs_clear: assert property (@(posedge clock) disable iff (reset)
        cmd_write && host_wdata[CMD_TR] && !core_in.tx_done |=> !tx_complete_flag)
        else $error("completion not cleared");
    a_cos_clear: assert property (@(posedge clock) disable iff (reset)
        cmd_write && host_wdata[CMD_COS] && !core_in.overrun_set |=> !overrun_flag)
        else $error("overrun not cleared");
    a_oie_gate: assert property (@(posedge clock) disable iff (reset)
        overrun_irq |-> $past(can_control_reg[CTL_OIE]) && $past(core_in.overrun_set))
        else $error("overrun irq without cause");
endmodule

// File: tb/cccr_bus_model.sv
// behavioural model of the other nodes on the shared bus
`timescale 1ns/1ps
module cccr_bus_model (
    input wire logic clock,
    output logic bit_tick,
    output logic bus_level
);
    // an idle bus rests recessive and the bit ticks stand still
    initial begin
        bit_tick = 1'b0;
        bus_level = 1'b1;
    end

    // bit runs at a chosen level
    // send n bits at one level, one tick every four clocks, then release
    task automatic send_bits(input int n, input logic level);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            bus_level = level;
            bit_tick = 1'b1;
            @(negedge clock);
            bit_tick = 1'b0;
            repeat (2) @(negedge clock);
        end
        bus_level = 1'b1;
    endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the can control and command registers
`timescale 1ns/1ps
module tb;
    import cccr_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] host_addr = 8'h00;
    logic [7:0] host_wdata = 8'h00;
    logic host_write = 1'b0;
    logic host_read = 1'b0;
    logic [7:0] host_rdata;
    logic [7:0] ev = 8'h00; // core event pulses and traffic levels
    logic bit_tick, bus_level;
    cccr_core_s core_in;
    logic irq_pending = 1'b0;
    logic bus_idle = 1'b1;
    cccr_cmd_s cmd_pulse;
    logic [7:0] control_out;
    logic core_in_reset, counters_clear, filter_access, resync_both_edges;
    logic rx_pin_a_bias, rx_pin_b_bias, sleep_comparator_select, sleeping;
    logic wake_irq, overrun_irq, error_irq, tx_irq, rx_irq, rx_enable;
    logic tx_complete_flag, overrun_flag;
    // sticky pulse record, so one-cycle pulses are never missed
    logic [5:0] seen = 6'h00;
    logic [7:0] d;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    always #2.5 clock = ~clock;
    assign core_in = cccr_core_s'({ev, bit_tick, bus_level});

    cccr_regs u_dut (.clock, .reset, .host_addr, .host_wdata, .host_write, .host_read,
        .host_rdata, .core_in, .irq_pending, .bus_idle, .cmd_pulse, .control_out,
        .core_in_reset, .counters_clear, .filter_access, .resync_both_edges,
        .rx_pin_a_bias, .rx_pin_b_bias, .sleep_comparator_select, .sleeping, .wake_irq,
        .overrun_irq, .error_irq, .tx_irq, .rx_irq, .rx_enable, .tx_complete_flag,
        .overrun_flag);
    cccr_bus_model u_bus (.clock, .bit_tick, .bus_level);

    // pulse capture and hang guard
    always @(posedge clock) begin
        seen <= seen | {counters_clear, wake_irq, overrun_irq, error_irq, tx_irq, rx_irq};
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask

    // host write: strobe for one clock, launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        host_addr = a;
        host_wdata = v;
        host_write = 1'b1;
        @(negedge clock);
        host_write = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        host_addr = a;
        host_read = 1'b1;
        @(negedge clock);
        host_read = 1'b0;
        d = host_rdata;
    endtask

    task automatic pulse_ev(input logic [7:0] e);
        @(negedge clock);
        ev = e;
        @(negedge clock);
        ev = 8'h00;
        repeat (2) @(negedge clock);
    endtask

    task automatic t_reset();
        rd(CCCR_ADDR_CONTROL);
        check(d, 8'h01);
        rd(CCCR_ADDR_COMMAND);
        check(d, 8'hFF);
        chkb(filter_access, 1'b1);
        wr(CCCR_ADDR_COMMAND, 8'h0F);
        check({4'h0, cmd_pulse}, 8'h00);
        wr(CCCR_ADDR_CONTROL, 8'h00);
        u_bus.send_bits(10, 1'b1);
        chkb(core_in_reset, 1'b1);
        u_bus.send_bits(1, 1'b1);
        chkb(core_in_reset, 1'b0);
        chkb(filter_access, 1'b0);
    endtask

    task automatic t_ctl();
        wr(CCCR_ADDR_CONTROL, 8'h5E);
        rd(CCCR_ADDR_CONTROL);
        check(d, 8'h5E);
        chkb(resync_both_edges, 1'b1);
        wr(CCCR_ADDR_CONTROL, 8'h1E);
        chkb(resync_both_edges, 1'b0);
    endtask

    task automatic t_cmd();
        pulse_ev(8'h20);
        chkb(tx_complete_flag, 1'b1);
        wr(CCCR_ADDR_COMMAND, 8'h0F);
        check({4'h0, cmd_pulse}, 8'h0F);
        chkb(tx_complete_flag, 1'b0);
        @(negedge clock);
        check({4'h0, cmd_pulse}, 8'h00);
        wr(CCCR_ADDR_COMMAND, 8'h00);
        check({4'h0, cmd_pulse}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(CCCR_ADDR_COMMAND, {i[1:0], 6'h00});
            chkb(rx_pin_a_bias, i[1] & ~i[0]);
            chkb(rx_pin_b_bias, i[0] & ~i[1]);
        end
        wr(CCCR_ADDR_COMMAND, 8'h20);
        chkb(sleep_comparator_select, 1'b1);
    endtask

    // each event against its interrupt, with enables off and on
    task automatic t_irq();
        logic [7:0] evs [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08};
        int idx [5] = '{3, 2, 1, 1, 0};
        for (int en = 0; en < 2; en++) begin
            wr(CCCR_ADDR_CONTROL, en[0] ? 8'h1E : 8'h00);
            for (int k = 0; k < 5; k++) begin
                seen = 6'h00;
                pulse_ev(evs[k]);
                chkb(seen[idx[k]], en[0]);
            end
        end
        chkb(overrun_flag, 1'b1);
        wr(CCCR_ADDR_COMMAND, 8'h04);
        chkb(overrun_flag, 1'b1);
        wr(CCCR_ADDR_COMMAND, 8'h0C);
        check({4'h0, cmd_pulse}, 8'h0C);
        @(negedge clock);
        chkb(overrun_flag, 1'b0);
    endtask

    task automatic try_sleep(input logic v, input logic slp, input logic wk);
        seen = 6'h00;
        wr(CCCR_ADDR_COMMAND, {3'h0, v, 4'h0});
        repeat (2) @(negedge clock);
        chkb(sleeping, slp);
        chkb(seen[4], wk);
    endtask

    task automatic t_sleep();
        try_sleep(1'b1, 1'b1, 1'b0);
        try_sleep(1'b0, 1'b0, 1'b0);
        irq_pending = 1'b1;
        try_sleep(1'b1, 1'b0, 1'b1);
        irq_pending = 1'b0;
        bus_idle = 1'b0;
        try_sleep(1'b1, 1'b0, 1'b1);
        bus_idle = 1'b1;
        ev = 8'h01;
        try_sleep(1'b1, 1'b0, 1'b1);
        ev = 8'h00;
        wr(CCCR_ADDR_COMMAND, 8'h00);
        try_sleep(1'b1, 1'b1, 1'b0);
        u_bus.send_bits(1, 1'b0);
        chkb(sleeping, 1'b0);
        chkb(seen[4], 1'b1);
        chkb(rx_enable, 1'b0);
        u_bus.send_bits(11, 1'b1);
        chkb(rx_enable, 1'b1);
    endtask

    task automatic t_busoff();
        seen = 6'h00;
        // host-raised request enters reset without clearing the error counters
        wr(CCCR_ADDR_CONTROL, 8'h1F);
        repeat (2) @(negedge clock);
        chkb(seen[5], 1'b0);
        chkb(core_in_reset, 1'b1);
        wr(CCCR_ADDR_CONTROL, 8'h1E);
        u_bus.send_bits(11, 1'b1);
        chkb(seen[5], 1'b0);
        pulse_ev(8'h04);
        rd(CCCR_ADDR_CONTROL);
        check(d, 8'h1F);
        check(control_out, 8'h1F);
        chkb(core_in_reset, 1'b1);
        wr(CCCR_ADDR_CONTROL, 8'h1E);
        u_bus.send_bits(127 * 11, 1'b1);
        chkb(core_in_reset, 1'b1);
        u_bus.send_bits(11, 1'b1);
        chkb(core_in_reset, 1'b0);
        chkb(seen[5], 1'b1);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        t_reset();
        t_ctl();
        t_cmd();
        t_irq();
        t_sleep();
        t_busoff();
        end_of_test();
    end
endmodule
